// [src/fbca_pkg.sv]
// Shared constants, query map and carrier types for the flash command host
package fbca_pkg;

    // Bus widths
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;
    localparam int CNT_W = 4;
    localparam int STEP_W = 4;
    localparam int PROT_OFS_W = 8;

    // Timing: figures in ns, cycles derived from the 100 MHz clock
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_WP_NS = 35;
    localparam int T_ACC_NS = 70;
    localparam logic [CNT_W-1:0] WP_CYC = CNT_W'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] ACC_CYC = CNT_W'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] SYNC_CYC = 4'h2;
    localparam logic [CNT_W-1:0] SETUP_CYC = 4'h1;
    localparam logic [CNT_W-1:0] HOLD_CYC = 4'h1;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

    // Command words and unlock addresses
    localparam logic [ADDR_W-1:0] UNLK1_ADDR = 22'h000555;
    localparam logic [DATA_W-1:0] UNLK1_DATA = 16'h00aa;
    localparam logic [ADDR_W-1:0] UNLK2_ADDR = 22'h0002aa;
    localparam logic [DATA_W-1:0] UNLK2_DATA = 16'h0055;
    localparam logic [DATA_W-1:0] AUTOSEL_CMD = 16'h0090;
    localparam logic [DATA_W-1:0] RESET_CMD = 16'h00f0;
    localparam logic [ADDR_W-1:0] QRY_ENTRY_ADDR = 22'h000055;
    localparam logic [DATA_W-1:0] QRY_ENTRY_DATA = 16'h0098;
    localparam logic [PROT_OFS_W-1:0] PROT_OFS = 8'h02;
    localparam int TO_FLAG_BIT = 5;

    // Query table map of the device, word offsets and expected contents
    localparam logic [7:0] BURST_SUPPORT_QUERY_OFS = 8'h4b;
    localparam logic [7:0] PAGE_READ_SUPPORT_QUERY_OFS = 8'h4c;
    localparam logic [7:0] ACCEL_SUPPLY_MIN_QUERY_OFS = 8'h4d;
    localparam logic [7:0] ACCEL_SUPPLY_MAX_QUERY_OFS = 8'h4e;
    localparam logic [7:0] BOOT_LAYOUT_FLAG_QUERY_OFS = 8'h4f;
    localparam logic [7:0] PROGRAM_SUSPEND_QUERY_OFS = 8'h50;
    localparam logic [7:0] BANK_COUNT_QUERY_OFS = 8'h57;
    localparam logic [7:0] BANK_ONE_SECTOR_COUNT_OFS = 8'h58;
    localparam logic [7:0] BANK_TWO_SECTOR_COUNT_OFS = 8'h59;
    localparam logic [7:0] BANK_THREE_SECTOR_COUNT_OFS = 8'h5a;
    localparam logic [7:0] BANK_FOUR_SECTOR_COUNT_OFS = 8'h5b;
    localparam logic [DATA_W-1:0] BURST_SUPPORT_QUERY_VAL = 16'h0000;
    localparam logic [DATA_W-1:0] PAGE_READ_SUPPORT_QUERY_VAL = 16'h0000;
    localparam logic [DATA_W-1:0] ACCEL_SUPPLY_MIN_QUERY_VAL = 16'h0085;
    localparam logic [DATA_W-1:0] ACCEL_SUPPLY_MAX_QUERY_VAL = 16'h0095;
    localparam logic [DATA_W-1:0] BOOT_LAYOUT_FLAG_QUERY_VAL = 16'h0004;
    localparam logic [DATA_W-1:0] PROGRAM_SUSPEND_QUERY_VAL = 16'h0001;
    localparam logic [DATA_W-1:0] BANK_COUNT_QUERY_VAL = 16'h0004;
    localparam logic [DATA_W-1:0] BANK_ONE_SECTOR_COUNT_VAL = 16'h0017;
    localparam logic [DATA_W-1:0] BANK_TWO_SECTOR_COUNT_VAL = 16'h0030;
    localparam logic [DATA_W-1:0] BANK_THREE_SECTOR_COUNT_VAL = 16'h0030;
    localparam logic [DATA_W-1:0] BANK_FOUR_SECTOR_COUNT_VAL = 16'h0017;

    localparam int QRY_N = 11;
    localparam logic [STEP_W-1:0] QRY_LAST_STEP = 4'hc;
    localparam logic [7:0] QRY_OFS [0:QRY_N-1] = '{
        BURST_SUPPORT_QUERY_OFS, PAGE_READ_SUPPORT_QUERY_OFS, ACCEL_SUPPLY_MIN_QUERY_OFS,
        ACCEL_SUPPLY_MAX_QUERY_OFS, BOOT_LAYOUT_FLAG_QUERY_OFS, PROGRAM_SUSPEND_QUERY_OFS,
        BANK_COUNT_QUERY_OFS, BANK_ONE_SECTOR_COUNT_OFS, BANK_TWO_SECTOR_COUNT_OFS,
        BANK_THREE_SECTOR_COUNT_OFS, BANK_FOUR_SECTOR_COUNT_OFS};
    localparam logic [DATA_W-1:0] QRY_VAL [0:QRY_N-1] = '{
        BURST_SUPPORT_QUERY_VAL, PAGE_READ_SUPPORT_QUERY_VAL, ACCEL_SUPPLY_MIN_QUERY_VAL,
        ACCEL_SUPPLY_MAX_QUERY_VAL, BOOT_LAYOUT_FLAG_QUERY_VAL, PROGRAM_SUSPEND_QUERY_VAL,
        BANK_COUNT_QUERY_VAL, BANK_ONE_SECTOR_COUNT_VAL, BANK_TWO_SECTOR_COUNT_VAL,
        BANK_THREE_SECTOR_COUNT_VAL, BANK_FOUR_SECTOR_COUNT_VAL};

    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_WRITE = 3'h1,
        OP_RESET = 3'h2,
        OP_AUTOSEL = 3'h3,
        OP_PROT = 3'h4,
        OP_POLL = 3'h5,
        OP_QCHK = 3'h6
    } fbca_op_t;

    typedef struct packed {
        fbca_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } fbca_req_t;

    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic [ADDR_W-1:0] addr;
    } fbca_pins_t;

endpackage

// [src/fbca_sync2.sv]
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module fbca_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule // fbca_sync2
`default_nettype wire

// [src/fbca_cycle.sv]
// Single asynchronous bus cycle engine: one read or one write on the flash pins
`timescale 1ns/1ps
`default_nettype none
module fbca_cycle (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Cycle request
    input wire logic start_i,
    input wire logic wr_i,
    input wire logic [fbca_pkg::ADDR_W-1:0] addr_i,
    input wire logic [fbca_pkg::DATA_W-1:0] wdata_i,
    input wire logic [fbca_pkg::DATA_W-1:0] dq_sync_i,
    output logic done_o,
    output logic [fbca_pkg::DATA_W-1:0] rdata_o,
    // Flash pins
    output fbca_pkg::fbca_pins_t pins_o,
    output logic [fbca_pkg::DATA_W-1:0] dq_o,
    output logic dq_oe_o
);
    import fbca_pkg::*;

    typedef enum logic [3:0] {
        PH_IDLE = 4'b0001,
        PH_SETUP = 4'b0010,
        PH_STROBE = 4'b0100,
        PH_HOLD = 4'b1000
    } fbca_phase_t;

    fbca_phase_t phase;
    logic [CNT_W-1:0] cnt;
    logic wr_q;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phase <= PH_IDLE;
            cnt <= '0;
            wr_q <= 1'b0;
            done_o <= 1'b0;
            pins_o <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0};
            dq_o <= '0;
            dq_oe_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (phase)
                PH_IDLE: begin
                    if (start_i) begin
                        // Address is set before either strobe falls and held to the end
                        pins_o.ce_n <= 1'b0;
                        pins_o.addr <= addr_i;
                        dq_o <= wdata_i;
                        dq_oe_o <= wr_i;
                        wr_q <= wr_i;
                        cnt <= SETUP_CYC;
                        phase <= PH_SETUP;
                    end
                end
                PH_SETUP: begin
                    if (cnt == CNT_ONE) begin
                        // Write strobe falls last, so it is the address-capturing edge
                        pins_o.we_n <= !wr_q;
                        pins_o.oe_n <= wr_q;
                        cnt <= wr_q ? WP_CYC : CNT_W'(ACC_CYC + SYNC_CYC);
                        phase <= PH_STROBE;
                    end else begin
                        cnt <= cnt - CNT_ONE;
                    end
                end
                PH_STROBE: begin
                    if (cnt == CNT_ONE) begin
                        // Write strobe rises first; data stays driven through hold
                        pins_o.we_n <= 1'b1;
                        pins_o.oe_n <= 1'b1;
                        cnt <= HOLD_CYC;
                        phase <= PH_HOLD;
                    end else begin
                        cnt <= cnt - CNT_ONE;
                    end
                end
                PH_HOLD: begin
                    if (cnt == CNT_ONE) begin
                        pins_o.ce_n <= 1'b1;
                        dq_oe_o <= 1'b0;
                        done_o <= 1'b1;
                        phase <= PH_IDLE;
                    end else begin
                        cnt <= cnt - CNT_ONE;
                    end
                end
                default: phase <= PH_IDLE;
            endcase
        end
    end

    // Synchroniser delay is folded into the strobe, so the sample is a settled word
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= '0;
        end else if (phase == PH_STROBE && cnt == CNT_ONE && !wr_q) begin
            rdata_o <= dq_sync_i;
        end
    end
endmodule // fbca_cycle
`default_nettype wire

// [src/fbca_host.sv]
// Host controller driving a multi-bank flash through its command interface
// Behaviour
// - Timeout flag high: host writes reset command
// - Only reset leaves autoselect mode
// - Autoselect only when no bank is busy
// - Two unlocks, then bank address plus command
// - Protect query carries bank and sector address
`timescale 1ns/1ps
`default_nettype none
module fbca_host (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // User request
    input wire logic req_valid_i,
    input wire fbca_pkg::fbca_req_t req_i,
    output logic req_ready_o,
    // User answer
    output logic done_o,
    output logic refused_o,
    output logic [fbca_pkg::DATA_W-1:0] rdata_o,
    output logic query_ok_o,
    output logic autosel_o,
    output logic timeout_o,
    output logic busy_o,
    // Flash pins
    output fbca_pkg::fbca_pins_t pins_o,
    input wire logic [fbca_pkg::DATA_W-1:0] dq_i,
    output logic [fbca_pkg::DATA_W-1:0] dq_o,
    output logic dq_oe_o,
    input wire logic flash_ready_i
);
    import fbca_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ISSUE = 3'b010,
        ST_WAIT = 3'b100
    } fbca_state_t;

    fbca_state_t state;
    fbca_req_t req_q;
    logic [STEP_W-1:0] step;
    logic [DATA_W-1:0] dq_sync;
    logic ready_sync;
    logic cyc_done;
    logic [DATA_W-1:0] cyc_rdata;
    logic st_wr;
    logic [ADDR_W-1:0] st_addr;
    logic [DATA_W-1:0] st_data;
    logic st_last;
    logic st_read_qry;
    logic refuse;
    logic busy;
    logic reset_done;
    logic poll_to;
    logic [3:0] qidx;

    fbca_sync2 #(.W(DATA_W)) u_dq_sync (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .d_i(dq_i),
        .q_o(dq_sync)
    );

    fbca_sync2 #(.W(1)) u_ready_sync (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .d_i(flash_ready_i),
        .q_o(ready_sync)
    );

    fbca_cycle u_cycle (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .start_i(state == ST_ISSUE),
        .wr_i(st_wr),
        .addr_i(st_addr),
        .wdata_i(st_data),
        .dq_sync_i(dq_sync),
        .done_o(cyc_done),
        .rdata_o(cyc_rdata),
        .pins_o(pins_o),
        .dq_o(dq_o),
        .dq_oe_o(dq_oe_o)
    );

    // A bank still running its algorithm holds the ready pin low
    assign busy = !ready_sync;
    assign busy_o = busy;
    assign req_ready_o = (state == ST_IDLE);
    assign qidx = step - 4'h1;

    // Cycle list of each operation, one step per bus cycle
    always_comb begin
        st_wr = 1'b0;
        st_addr = req_q.addr;
        st_data = req_q.wdata;
        st_last = 1'b1;
        st_read_qry = 1'b0;
        case (req_q.op)
            OP_WRITE: begin
                st_wr = 1'b1;
            end
            OP_RESET: begin
                // Any address will do for the reset word
                st_wr = 1'b1;
                st_data = RESET_CMD;
            end
            OP_AUTOSEL: begin
                st_wr = 1'b1;
                st_last = (step == 4'h2);
                if (step == 4'h0) begin
                    st_addr = UNLK1_ADDR;
                    st_data = UNLK1_DATA;
                end else if (step == 4'h1) begin
                    st_addr = UNLK2_ADDR;
                    st_data = UNLK2_DATA;
                end else begin
                    st_data = AUTOSEL_CMD;
                end
            end
            OP_PROT: begin
                // Upper bits carry bank and sector, low bits the protect offset
                st_addr = {req_q.addr[ADDR_W-1:PROT_OFS_W], PROT_OFS};
            end
            OP_POLL: begin
                if (step == 4'h0) begin
                    st_last = !cyc_rdata[TO_FLAG_BIT];
                end else begin
                    st_wr = 1'b1;
                    st_data = RESET_CMD;
                end
            end
            OP_QCHK: begin
                st_last = (step == QRY_LAST_STEP);
                if (step == 4'h0) begin
                    st_wr = 1'b1;
                    st_addr = QRY_ENTRY_ADDR;
                    st_data = QRY_ENTRY_DATA;
                end else if (step == QRY_LAST_STEP) begin
                    st_wr = 1'b1;
                    st_data = RESET_CMD;
                end else begin
                    st_read_qry = 1'b1;
                    st_addr = {{(ADDR_W - 8){1'b0}}, QRY_OFS[qidx]};
                end
            end
            default: begin
                st_wr = 1'b0;
            end
        endcase
    end

    // Requests the device would ignore or that break its mode rules are refused
    always_comb begin
        refuse = 1'b0;
        case (req_i.op)
            OP_AUTOSEL: refuse = busy;
            OP_QCHK: refuse = busy;
            OP_PROT: refuse = !autosel_o;
            OP_RESET: refuse = busy && !timeout_o;
            default: refuse = 1'b0;
        endcase
    end

    assign reset_done = (state == ST_WAIT) && cyc_done && st_wr && (st_data == RESET_CMD);
    assign poll_to = (state == ST_WAIT) && cyc_done && (req_q.op == OP_POLL)
        && (step == 4'h0) && cyc_rdata[TO_FLAG_BIT];

    // Sequencer: steps of one operation are issued back to back so none is misordered
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= ST_IDLE;
            req_q <= '{op: OP_READ, addr: '0, wdata: '0};
            step <= '0;
            done_o <= 1'b0;
            refused_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            refused_o <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (req_valid_i) begin
                        if (refuse) begin
                            refused_o <= 1'b1;
                        end else begin
                            req_q <= req_i;
                            step <= '0;
                            state <= ST_ISSUE;
                        end
                    end
                end
                ST_ISSUE: begin
                    state <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (cyc_done) begin
                        if (st_last) begin
                            done_o <= 1'b1;
                            state <= ST_IDLE;
                        end else begin
                            step <= step + 4'h1;
                            state <= ST_ISSUE;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Read results of plain, poll and protect reads
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= '0;
        end else if (state == ST_WAIT && cyc_done && !st_wr && !st_read_qry) begin
            rdata_o <= cyc_rdata;
        end
    end

    // Query table check; any mismatching word clears the verdict
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            query_ok_o <= 1'b0;
        end else if (state == ST_IDLE && req_valid_i && !refuse && req_i.op == OP_QCHK) begin
            query_ok_o <= 1'b1;
        end else if (state == ST_WAIT && cyc_done && st_read_qry) begin
            if (cyc_rdata != QRY_VAL[qidx]) begin
                query_ok_o <= 1'b0;
            end
        end
    end

    // Autoselect stays until a reset word is written; reset starts in array read
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            autosel_o <= 1'b0;
        end else if (state == ST_WAIT && cyc_done && st_last && req_q.op == OP_AUTOSEL) begin
            autosel_o <= 1'b1;
        end else if (reset_done) begin
            autosel_o <= 1'b0;
        end
    end

    // Timeout seen by a poll lets a reset through a busy bank; set wins over clear
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            timeout_o <= 1'b0;
        end else if (poll_to) begin
            timeout_o <= 1'b1;
        end else if (reset_done) begin
            timeout_o <= 1'b0;
        end
    end
endmodule // fbca_host
`default_nettype wire

// [sim/fbca_host_chk.sv]
// Port-level checker for the flash command host
`timescale 1ns/1ps
`default_nettype none
module fbca_host_chk (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // User side
    input wire logic req_valid_i,
    input wire fbca_pkg::fbca_req_t req_i,
    input wire logic req_ready_o,
    input wire logic done_o,
    input wire logic refused_o,
    input wire logic [fbca_pkg::DATA_W-1:0] rdata_o,
    input wire logic query_ok_o,
    input wire logic autosel_o,
    input wire logic timeout_o,
    input wire logic busy_o,
    // Flash pins
    input wire fbca_pkg::fbca_pins_t pins_o,
    input wire logic [fbca_pkg::DATA_W-1:0] dq_i,
    input wire logic [fbca_pkg::DATA_W-1:0] dq_o,
    input wire logic dq_oe_o,
    input wire logic flash_ready_i
);
    import fbca_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    logic take;
    assign take = req_valid_i && req_ready_o;

    strobe_idle_a: assert property (pins_o.ce_n |-> pins_o.we_n && pins_o.oe_n)
        else $error("strobe active while deselected");
    addr_hold_a: assert property (!pins_o.ce_n && $past(!pins_o.ce_n) |-> $stable(pins_o.addr))
        else $error("address moved inside a bus cycle");
    addr_edge_a: assert property ($fell(pins_o.we_n) |-> $past(!pins_o.ce_n))
        else $error("write strobe fell before select");
    data_edge_a: assert property ($rose(pins_o.we_n) |-> dq_oe_o && !pins_o.ce_n && $stable(dq_o))
        else $error("data not held across write strobe rise");
    strobe_width_a: assert property ($fell(pins_o.we_n) |-> !pins_o.we_n [*4] ##1 pins_o.we_n)
        else $error("write strobe width wrong");
    prot_refuse_a: assert property (take && req_i.op == OP_PROT && !autosel_o |=> refused_o)
        else $error("protect query outside autoselect not refused");
    busy_refuse_a: assert property (take && busy_o && req_i.op == OP_AUTOSEL |=> refused_o)
        else $error("autoselect while busy not refused");
    reset_clear_a: assert property ($rose(pins_o.we_n) && dq_o == RESET_CMD |-> ##[1:12] !autosel_o)
        else $error("reset word did not clear autoselect");
    read_done_a: assert property (take && req_i.op == OP_READ |-> ##[12:14] done_o)
        else $error("read did not complete in time");
    entry_a: assert property (take && req_i.op == OP_AUTOSEL && !busy_o |-> ##[20:60] autosel_o)
        else $error("autoselect entry not reached");
    timeout_clear_a: assert property ($rose(timeout_o) |-> ##[8:12] !timeout_o)
        else $error("timeout flag not cleared by reset write");

    cover property (take && req_i.op == OP_QCHK);
    cover property ($rose(autosel_o));
    cover property (refused_o);
endmodule // fbca_host_chk
`default_nettype wire

// [sim/fbca_flash_model.sv]
// Behavioural model of the flash command interface and query table
`timescale 1ns/1ps
`default_nettype none
module fbca_flash_model #(
    parameter logic [15:0] ID_CODE = 16'h1234 // Arbitrary identification word
) (
    // Clock
    input wire logic clk_sys_i,
    // Flash pins
    input wire fbca_pkg::fbca_pins_t pins_i,
    input wire logic [fbca_pkg::DATA_W-1:0] dq_i,
    output logic [fbca_pkg::DATA_W-1:0] dq_o,
    output logic ready_o,
    // Bench controls
    input wire logic hold_busy_i,
    input wire logic err_i,
    input wire logic [13:0] prot_sect_i
);
    import fbca_pkg::*;
    // Kept apart from the package so a wrong package value cannot hide
    localparam logic [7:0] OFS [0:10] = '{8'h4b, 8'h4c, 8'h4d, 8'h4e, 8'h4f, 8'h50, 8'h57,
        8'h58, 8'h59, 8'h5a, 8'h5b};
    localparam logic [15:0] VAL [0:10] = '{16'h0, 16'h0, 16'h85, 16'h95, 16'h4, 16'h1,
        16'h4, 16'h17, 16'h30, 16'h30, 16'h17};
    logic [ADDR_W-1:0] a_lat;
    logic [DATA_W-1:0] rd;
    logic [DATA_W-1:0] last;
    logic qry;
    logic asel;
    logic fault;
    int step;
    initial begin
        qry = 1'b0;
        asel = 1'b0;
        fault = 1'b0;
        step = 0;
        last = 16'h0;
        a_lat = '0;
    end
    // One process keeps the latch single-driven; the later of the two falls takes it
    always @(negedge pins_i.we_n or negedge pins_i.ce_n) begin
        if (!pins_i.ce_n && !pins_i.we_n) a_lat = pins_i.addr;
    end
    always @(posedge err_i) fault = 1'b1;
    always @(posedge pins_i.we_n) begin
        if (!pins_i.ce_n) begin
            if (dq_i == RESET_CMD) begin
                step = 0;
                qry = 1'b0;
                asel = 1'b0;
                fault = 1'b0;
            end else if (step == 0 && a_lat == UNLK1_ADDR && dq_i == UNLK1_DATA) step = 1;
            else if (step == 1 && a_lat == UNLK2_ADDR && dq_i == UNLK2_DATA) step = 2;
            else if (step == 2 && dq_i == AUTOSEL_CMD) begin
                step = 0;
                asel = 1'b1;
            end else if (step == 0 && a_lat == QRY_ENTRY_ADDR && dq_i == QRY_ENTRY_DATA) qry = 1'b1;
            else step = 0;
        end
    end
    always_comb begin
        rd = fault ? 16'h0020 : pins_i.addr[15:0] ^ 16'ha5c3;
        if (asel) rd = (pins_i.addr[7:0] == PROT_OFS) ?
            {15'h0, pins_i.addr[21:8] == prot_sect_i} : ID_CODE;
        if (qry) for (int i = 0; i < 11; i++) if (pins_i.addr[7:0] == OFS[i]) rd = VAL[i];
    end
    // Undriven bus shows the inverse of the last word so stale data cannot pass
    assign dq_o = (!pins_i.ce_n && !pins_i.oe_n) ? rd : ~last;
    always @(posedge clk_sys_i) if (!pins_i.ce_n && !pins_i.oe_n) last <= rd;
    assign ready_o = !hold_busy_i;
endmodule // fbca_flash_model
`default_nettype wire

// [sim/fbca_host_tb.sv]
// Self-checking testbench for the flash command host
`timescale 1ns/1ps
`default_nettype none
module fbca_host_tb;
    import fbca_pkg::*;
    localparam logic [15:0] ID = 16'h3c5a; // Arbitrary identification word
    logic clk_sys_i, arst_n_i, req_valid_i, req_ready_o, done_o, refused_o, query_ok_o;
    logic autosel_o, timeout_o, busy_o, dq_oe_o, flash_ready_i, hold_busy, err, refd, to_seen;
    fbca_req_t req_i;
    fbca_pins_t pins_o;
    logic [DATA_W-1:0] rdata_o, dq_i, dq_o, flash_dq;
    int n_errors, n_checks;
    assign dq_i = dq_oe_o ? dq_o : flash_dq;

    fbca_host i_fbca_host (.clk_sys_i, .arst_n_i, .req_valid_i, .req_i, .req_ready_o, .done_o,
        .refused_o, .rdata_o, .query_ok_o, .autosel_o, .timeout_o, .busy_o, .pins_o, .dq_i,
        .dq_o, .dq_oe_o, .flash_ready_i);
    fbca_flash_model #(.ID_CODE(ID)) i_fbca_flash_model (.clk_sys_i, .pins_i(pins_o), .dq_i,
        .dq_o(flash_dq), .ready_o(flash_ready_i), .hold_busy_i(hold_busy), .err_i(err),
        .prot_sect_i(14'h0123));

    function automatic logic [15:0] arr(input logic [21:0] a);
        return a[15:0] ^ 16'ha5c3;
    endfunction
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Entered just after a rising edge; returns one edge after the answer
    task automatic run(input fbca_op_t op, input logic [21:0] a, input logic [15:0] d);
        int k;
        req_valid_i <= 1'b1;
        req_i <= '{op: op, addr: a, wdata: d};
        @(posedge clk_sys_i);
        req_valid_i <= 1'b0;
        for (k = 0; k < 400; k++) begin
            @(negedge clk_sys_i);
            if (done_o === 1'b1 || refused_o === 1'b1) break;
        end
        refd = refused_o;
        if (k == 400) chk("answer", 16'h0, 16'h1);
        @(posedge clk_sys_i);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // The timeout flag stands only while the host writes its reset word
    always @(posedge clk_sys_i) if (timeout_o === 1'b1) to_seen <= 1'b1;
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #100000;
        n_errors++;
        $display("[ERR] watchdog expired");
        finish_test();
    end
    initial begin
        arst_n_i = 1'b0;
        req_valid_i = 1'b0;
        req_i = '0;
        hold_busy = 1'b0;
        err = 1'b0;
        refd = 1'b0;
        to_seen = 1'b0;
        n_errors = 0;
        n_checks = 0;
        repeat (2) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        run(OP_READ, 22'h012345, 16'h0);
        chk("array read", rdata_o, arr(22'h012345));
        $display("test power-up read done");
        run(OP_WRITE, QRY_ENTRY_ADDR, QRY_ENTRY_DATA);
        for (int i = 0; i < QRY_N; i++) begin
            run(OP_READ, {14'h0, QRY_OFS[i]}, 16'h0);
            chk("query word", rdata_o, QRY_VAL[i]);
        end
        run(OP_RESET, 22'h3fffff, 16'h0);
        run(OP_READ, 22'h00004d, 16'h0);
        chk("read after reset", rdata_o, arr(22'h00004d));
        run(OP_QCHK, 22'h000000, 16'h0);
        chk("query check", query_ok_o, 1'b1);
        $display("test query table done");
        run(OP_PROT, 22'h012300, 16'h0);
        chk("protect refused", refd, 1'b1);
        run(OP_AUTOSEL, 22'h100000, 16'h0);
        chk("autoselect flag", autosel_o, 1'b1);
        run(OP_PROT, 22'h012300, 16'h0);
        chk("protected sector", rdata_o, 16'h1);
        run(OP_PROT, 22'h012400, 16'h0);
        chk("open sector", rdata_o, 16'h0);
        run(OP_READ, 22'h000001, 16'h0);
        chk("id word", rdata_o, ID);
        run(OP_WRITE, 22'h2aaaaa, RESET_CMD);
        chk("autoselect left", autosel_o, 1'b0);
        run(OP_READ, 22'h000001, 16'h0);
        chk("array again", rdata_o, arr(22'h000001));
        $display("test autoselect done");
        run(OP_WRITE, UNLK1_ADDR, UNLK1_DATA);
        run(OP_WRITE, UNLK2_ADDR, 16'h0077);
        run(OP_WRITE, 22'h100000, AUTOSEL_CMD);
        run(OP_READ, 22'h000002, 16'h0);
        chk("bad sequence", rdata_o, arr(22'h000002));
        run(OP_WRITE, UNLK1_ADDR, UNLK1_DATA);
        run(OP_WRITE, UNLK2_ADDR, UNLK2_DATA);
        run(OP_RESET, 22'h100000, 16'h0);
        run(OP_WRITE, 22'h100000, AUTOSEL_CMD);
        run(OP_READ, 22'h000003, 16'h0);
        chk("reset mid sequence", rdata_o, arr(22'h000003));
        $display("test bad sequence done");
        hold_busy <= 1'b1;
        repeat (4) @(negedge clk_sys_i);
        chk("busy seen", busy_o, 1'b1);
        @(posedge clk_sys_i);
        run(OP_AUTOSEL, 22'h100000, 16'h0);
        chk("autoselect refused", refd, 1'b1);
        run(OP_QCHK, 22'h000000, 16'h0);
        chk("query refused", refd, 1'b1);
        run(OP_RESET, 22'h000000, 16'h0);
        chk("reset refused", refd, 1'b1);
        hold_busy <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        $display("test busy done");
        err <= 1'b1;
        @(posedge clk_sys_i);
        run(OP_POLL, 22'h000010, 16'h0);
        chk("poll status", rdata_o, 16'h0020);
        chk("timeout seen", to_seen, 1'b1);
        chk("timeout cleared", timeout_o, 1'b0);
        err <= 1'b0;
        @(posedge clk_sys_i);
        run(OP_READ, 22'h000010, 16'h0);
        chk("read after fault", rdata_o, arr(22'h000010));
        $display("test timeout done");
        finish_test();
    end
endmodule // fbca_host_tb

bind fbca_host fbca_host_chk i_fbca_host_chk (.clk_sys_i, .arst_n_i, .req_valid_i, .req_i,
    .req_ready_o, .done_o, .refused_o, .rdata_o, .query_ok_o, .autosel_o, .timeout_o, .busy_o,
    .pins_o, .dq_i, .dq_o, .dq_oe_o, .flash_ready_i);
`default_nettype wire
